// ==== inc/oms_pkg.sv ====
// Constants, modes and register map of the operation mode selector
// Behaviour
// - Modes 0,2: network switching only while stopped
// - Mode 6 switches also while running
// - Network-panel switch on gives panel, else network
// - Startup 10: modes 1,2,3/4 fixed
// - Network-external switch on overrides panel to network
// - Network-panel switch never yields external mode
// - Mode 7 interlock on, startup 10: panel-external switch selects
// - Network-external switch on gives network, else external
// - Startup 0/1, mode 2: never panel mode
// - Mode 7: interlock stops output or forces external
// - External fallback yields network-panel, else panel-external choice, else external if network-external assigned, else the mode held
// - Fixed priority among settings and switch signals
// - Mode and startup settings reset to zero
// - Panel-external switch: on external, off panel
package oms_pkg;
   // Operation modes
   typedef enum logic [1:0] {
      OMS_EXT,
      OMS_PANEL,
      OMS_NET,
      OMS_COMB
   } oms_mode_e;

   // Register byte offsets
   localparam logic [7:0] OMS_OFS_OP_MODE = 8'h00;
   localparam logic [7:0] OMS_OFS_COMM = 8'h04;
   localparam logic [7:0] OMS_OFS_TERM0 = 8'h08;
   localparam logic [7:0] OMS_OFS_STATUS = 8'h1c;

   // Terminal count and field widths
   localparam int OMS_NUM_TERM = 5;
   localparam int OMS_SET_W = 4;
   localparam int OMS_FUNC_W = 7;

   // Status field positions
   localparam int OMS_ST_MODE_LSB = 0;
   localparam int OMS_ST_STOP_POS = 2;
   localparam int OMS_ST_IDLE_POS = 3;
   localparam int OMS_ST_PEND_POS = 4;

   // Reset values
   localparam logic [3:0] OMS_OP_RST = 4'h0;
   localparam logic [3:0] OMS_COMM_RST = 4'h0;
   localparam logic [6:0] OMS_FUNC_RST = 7'h7f;

   // Terminal function codes
   localparam logic [6:0] OMS_FN_NET_PU = 7'h41;
   localparam logic [6:0] OMS_FN_NET_EXT = 7'h42;
   localparam logic [6:0] OMS_FN_PU_EXT = 7'h10;
   localparam logic [6:0] OMS_FN_INTERLOCK = 7'h0c;
   localparam logic [6:0] OMS_FN_OUT_STOP = 7'h18;

   // Operation mode selection values
   localparam logic [3:0] OMS_OP_SWITCH = 4'h0;
   localparam logic [3:0] OMS_OP_PANEL = 4'h1;
   localparam logic [3:0] OMS_OP_EXTNET = 4'h2;
   localparam logic [3:0] OMS_OP_COMB3 = 4'h3;
   localparam logic [3:0] OMS_OP_COMB4 = 4'h4;
   localparam logic [3:0] OMS_OP_RUNSW = 4'h6;
   localparam logic [3:0] OMS_OP_LOCK = 4'h7;

   // Communication startup values
   localparam logic [3:0] OMS_COMM_PANELNET = 4'ha;

   // Bus responses
   localparam logic [1:0] OMS_RESP_OKAY = 2'h0;
   localparam logic [1:0] OMS_RESP_SLVERR = 2'h2;
endpackage

// ==== inc/oms_if.sv ====
// Bundle between register core and mode resolver
interface oms_if;
   logic [3:0] op_mode;              // Operation mode selection
   logic [3:0] comm_sel;             // Communication startup selection
   logic net_pu;                     // Network-panel switch level
   logic net_ext;                    // Network-external switch level
   logic pu_ext;                     // Panel-external switch level
   logic interlock;                  // Panel interlock level
   logic net_pu_asg;                 // Network-panel switch assigned
   logic net_ext_asg;                // Network-external switch assigned
   logic pu_ext_asg;                 // Panel-external switch assigned
   oms_pkg::oms_mode_e cur_mode;     // Mode now held
   oms_pkg::oms_mode_e target;       // Mode the settings ask for
   modport core (output op_mode, output comm_sel, output net_pu, output net_ext, output pu_ext,
      output interlock, output net_pu_asg, output net_ext_asg, output pu_ext_asg,
      output cur_mode, input target);
   modport res (input op_mode, input comm_sel, input net_pu, input net_ext, input pu_ext,
      input interlock, input net_pu_asg, input net_ext_asg, input pu_ext_asg,
      input cur_mode, output target);
endinterface

// ==== core/oms_resolve.sv ====
// Combinational resolver of the requested operation mode
module oms_resolve (
   oms_if.res bus
);
   // Fallback when the external mode would result
   function automatic oms_pkg::oms_mode_e ext_fallback(input logic npu_asg, input logic npu,
      input logic pe_asg, input logic pe, input logic ne_asg, input oms_pkg::oms_mode_e cur);
      oms_pkg::oms_mode_e m;
      m = cur;
      if (npu_asg) begin
         m = npu ? oms_pkg::OMS_PANEL : oms_pkg::OMS_NET;
      end else if (pe_asg) begin
         m = pe ? oms_pkg::OMS_EXT : oms_pkg::OMS_PANEL;
      end else if (ne_asg) begin
         m = oms_pkg::OMS_EXT;
      end
      return m;
   endfunction

   // Priority walk: setting, interlock, startup, net-ext, net-pu, pu-ext
   always_comb begin
      bus.target = bus.cur_mode;
      case (bus.op_mode)
         // Fixed panel mode
         oms_pkg::OMS_OP_PANEL: begin
            bus.target = oms_pkg::OMS_PANEL;
         end
         // Combined external and panel mode
         oms_pkg::OMS_OP_COMB3, oms_pkg::OMS_OP_COMB4: begin
            bus.target = oms_pkg::OMS_COMB;
         end
         // Network fixed, or network and external only
         oms_pkg::OMS_OP_EXTNET: begin
            if (bus.comm_sel == oms_pkg::OMS_COMM_PANELNET) begin
               bus.target = oms_pkg::OMS_NET;
            end else if (bus.net_ext_asg && bus.net_ext) begin
               bus.target = oms_pkg::OMS_NET;
            end else begin
               bus.target = oms_pkg::OMS_EXT;
            end
         end
         // Interlocked mode
         oms_pkg::OMS_OP_LOCK: begin
            if (!bus.interlock) begin
               bus.target = oms_pkg::OMS_EXT;
            end else if (bus.comm_sel == oms_pkg::OMS_COMM_PANELNET) begin
               bus.target = bus.pu_ext ? oms_pkg::OMS_EXT : oms_pkg::OMS_PANEL;
            end else if (bus.net_ext_asg && bus.net_ext) begin
               bus.target = oms_pkg::OMS_NET;
            end else begin
               bus.target = ext_fallback(bus.net_pu_asg, bus.net_pu, bus.pu_ext_asg, bus.pu_ext,
                  bus.net_ext_asg, bus.cur_mode);
            end
         end
         // Free switching modes
         oms_pkg::OMS_OP_SWITCH, oms_pkg::OMS_OP_RUNSW: begin
            if (bus.comm_sel == oms_pkg::OMS_COMM_PANELNET) begin
               // Never external here
               if (bus.net_pu_asg && bus.net_pu) begin
                  bus.target = (bus.net_ext_asg && bus.net_ext) ? oms_pkg::OMS_NET : oms_pkg::OMS_PANEL;
               end else begin
                  bus.target = oms_pkg::OMS_NET;
               end
            end else if (bus.net_ext_asg && bus.net_ext) begin
               bus.target = oms_pkg::OMS_NET;
            end else begin
               bus.target = ext_fallback(bus.net_pu_asg, bus.net_pu, bus.pu_ext_asg, bus.pu_ext,
                  bus.net_ext_asg, bus.cur_mode);
            end
         end
         // Unused setting holds the mode
         default: begin
            bus.target = bus.cur_mode;
         end
      endcase
   end
endmodule

// ==== core/oms_top.sv ====
// Operation mode selector with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite register port and the address map.
module oms_top #(
   parameter int NUM_TERM = oms_pkg::OMS_NUM_TERM
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic motor_running_in,
   input wire logic start_cmd_in,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [1:0] mode_out,
   output logic output_stop_out
);
   localparam int SW = oms_pkg::OMS_SET_W;
   localparam int FW = oms_pkg::OMS_FUNC_W;

   // Register selector codes
   localparam logic [3:0] SEL_OP = 4'h0;
   localparam logic [3:0] SEL_COMM = 4'h1;
   localparam logic [3:0] SEL_STAT = 4'h2;
   localparam logic [3:0] SEL_TERM = 4'h3;
   localparam logic [3:0] SEL_NONE = 4'hf;

   oms_if res_bus ();                            // Link to the resolver

   // Synchroniser stages for pins
   logic [NUM_TERM+1:0] pin_meta_reg;             // First stage only
   logic [NUM_TERM+1:0] pin_sync_reg;             // Safe to read

   // Settings
   logic [SW-1:0] op_mode_reg;                    // Operation mode selection
   logic [SW-1:0] comm_reg;                       // Communication startup selection
   logic [FW-1:0] term_func_reg [NUM_TERM];       // Function code per terminal

   // Mode state
   oms_pkg::oms_mode_e mode_reg;                  // Selected mode
   logic stop_reg;                                // Output stop level

   // Bus state
   logic aw_have_reg;                             // Write address held
   logic [7:0] aw_addr_reg;                       // Held write address
   logic w_have_reg;                              // Write data held
   logic [31:0] w_data_reg;                       // Held write data
   logic [3:0] w_strb_reg;                        // Held byte enables
   logic bvalid_reg;                              // Write answer pending
   logic [1:0] bresp_reg;                         // Write answer code
   logic rvalid_reg;                              // Read answer pending
   logic [31:0] rdata_reg;                        // Read answer data
   logic [1:0] rresp_reg;                         // Read answer code

   // Decoded terminal and motor levels
   logic [NUM_TERM-1:0] term_lvl;
   logic motor_idle;                              // Stopped or no start command
   logic lock_asg;                                // Interlock function assigned
   logic mrs_asg;                                 // Output stop function assigned
   logic mrs_lvl;                                 // Output stop level
   logic lock_lvl;                                // Effective interlock level
   logic pending;                                 // Request waiting for a stop
   logic may_switch;                              // Mode change allowed now
   logic do_write;                                // Both write halves present
   logic [3:0] wr_sel;                            // Decoded write target
   logic [3:0] rd_sel;                            // Decoded read target

   // Address to register selector, used by both channels
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - oms_pkg::OMS_OFS_TERM0;
      if (addr[1:0] != 2'h0) begin
         reg_sel = SEL_NONE;
      end else if (addr == oms_pkg::OMS_OFS_OP_MODE) begin
         reg_sel = SEL_OP;
      end else if (addr == oms_pkg::OMS_OFS_COMM) begin
         reg_sel = SEL_COMM;
      end else if (addr == oms_pkg::OMS_OFS_STATUS) begin
         reg_sel = SEL_STAT;
      end else if (addr >= oms_pkg::OMS_OFS_TERM0 && rel[7:2] < 6'(NUM_TERM)) begin
         reg_sel = SEL_TERM;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

   // Terminal index from a terminal register address
   function automatic int term_idx(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - oms_pkg::OMS_OFS_TERM0;
      term_idx = int'(rel[7:2]);
   endfunction

   // Level of a function over all terminals routed to it
   function automatic logic func_lvl(input logic [FW-1:0] code, input logic [NUM_TERM-1:0] lvl);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         r = r | (lvl[i] && term_func_reg[i] == code);
      end
      return r;
   endfunction

   // Whether any terminal carries a function
   function automatic logic func_asg(input logic [FW-1:0] code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         r = r | (term_func_reg[i] == code);
      end
      return r;
   endfunction

   // Two-flop synchroniser for pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {start_cmd_in, motor_running_in, term_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Function routing and run state
   always_comb begin
      term_lvl = pin_sync_reg[NUM_TERM-1:0];
      motor_idle = !pin_sync_reg[NUM_TERM] || !pin_sync_reg[NUM_TERM+1];
      lock_asg = func_asg(oms_pkg::OMS_FN_INTERLOCK);
      mrs_asg = func_asg(oms_pkg::OMS_FN_OUT_STOP);
      mrs_lvl = func_lvl(oms_pkg::OMS_FN_OUT_STOP, term_lvl);
      // Switch levels and routing here, so new function codes are seen at once
      res_bus.net_pu = func_lvl(oms_pkg::OMS_FN_NET_PU, term_lvl);
      res_bus.net_ext = func_lvl(oms_pkg::OMS_FN_NET_EXT, term_lvl);
      res_bus.pu_ext = func_lvl(oms_pkg::OMS_FN_PU_EXT, term_lvl);
      res_bus.net_pu_asg = func_asg(oms_pkg::OMS_FN_NET_PU);
      res_bus.net_ext_asg = func_asg(oms_pkg::OMS_FN_NET_EXT);
      res_bus.pu_ext_asg = func_asg(oms_pkg::OMS_FN_PU_EXT);
      // Output stop terminal doubles as interlock when none is routed
      if (lock_asg) begin
         lock_lvl = func_lvl(oms_pkg::OMS_FN_INTERLOCK, term_lvl);
      end else if (mrs_asg) begin
         lock_lvl = mrs_lvl;
      end else begin
         lock_lvl = 1'b1;
      end
   end

   // Resolver inputs
   assign res_bus.op_mode = op_mode_reg;
   assign res_bus.comm_sel = comm_reg;
   assign res_bus.interlock = lock_lvl;
   assign res_bus.cur_mode = mode_reg;

   oms_resolve u_resolve (
      .bus(res_bus)
   );

   // Change allowed when idle, in running switchover, or forced external
   always_comb begin
      may_switch = motor_idle;
      if (op_mode_reg == oms_pkg::OMS_OP_RUNSW) begin
         may_switch = 1'b1;
      end else if (op_mode_reg == oms_pkg::OMS_OP_LOCK && !lock_lvl) begin
         may_switch = 1'b1;
      end
      pending = (res_bus.target != mode_reg) && !may_switch;
   end

   // Mode state register, deferred requests apply at the stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= oms_pkg::OMS_EXT;
      end else if (may_switch) begin
         mode_reg <= res_bus.target;
      end
   end

   // Output stop: in mode 7 interlock while external (else low), other modes plain stop input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_reg <= 1'b0;
      end else if (op_mode_reg == oms_pkg::OMS_OP_LOCK) begin
         stop_reg <= lock_lvl && (lock_asg || mrs_asg) && mode_reg == oms_pkg::OMS_EXT;
      end else begin
         stop_reg <= mrs_lvl;
      end
   end

   // Write path decode
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   assign wr_sel = reg_sel(aw_addr_reg);
   assign rd_sel = reg_sel(s_axi_araddr);

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         // Address taken
         if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_reg <= 1'b0;
         end
         // Data taken
         if (s_axi_wvalid && !w_have_reg) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   // Setting registers, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_mode_reg <= oms_pkg::OMS_OP_RST;
         comm_reg <= oms_pkg::OMS_COMM_RST;
         for (int i = 0; i < NUM_TERM; i++) begin
            term_func_reg[i] <= oms_pkg::OMS_FUNC_RST;
         end
      end else if (do_write && w_strb_reg[0]) begin
         if (wr_sel == SEL_OP) begin
            op_mode_reg <= w_data_reg[SW-1:0];
         end else if (wr_sel == SEL_COMM) begin
            comm_reg <= w_data_reg[SW-1:0];
         end else if (wr_sel == SEL_TERM) begin
            term_func_reg[term_idx(aw_addr_reg)] <= w_data_reg[FW-1:0];
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= oms_pkg::OMS_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         // Status and unmapped words refuse writes
         if (wr_sel == SEL_NONE || wr_sel == SEL_STAT) begin
            bresp_reg <= oms_pkg::OMS_RESP_SLVERR;
         end else begin
            bresp_reg <= oms_pkg::OMS_RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read channel, answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= oms_pkg::OMS_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= oms_pkg::OMS_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         if (rd_sel == SEL_OP) begin
            rdata_reg[SW-1:0] <= op_mode_reg;
         end else if (rd_sel == SEL_COMM) begin
            rdata_reg[SW-1:0] <= comm_reg;
         end else if (rd_sel == SEL_TERM) begin
            rdata_reg[FW-1:0] <= term_func_reg[term_idx(s_axi_araddr)];
         end else if (rd_sel == SEL_STAT) begin
            rdata_reg[oms_pkg::OMS_ST_MODE_LSB+:2] <= mode_reg;
            rdata_reg[oms_pkg::OMS_ST_STOP_POS] <= stop_reg;
            rdata_reg[oms_pkg::OMS_ST_IDLE_POS] <= motor_idle;
            rdata_reg[oms_pkg::OMS_ST_PEND_POS] <= pending;
         end else begin
            rresp_reg <= oms_pkg::OMS_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready = !aw_have_reg;
   assign s_axi_wready = !w_have_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign mode_out = mode_reg;
   assign output_stop_out = stop_reg;
endmodule

// ==== bench/oms_chk.sv ====
// Port-level assertions for the operation mode selector
module oms_chk #(
   parameter int NUM_TERM = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic motor_running_in,
   input wire logic start_cmd_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [1:0] mode_out,
   input wire logic output_stop_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] quiet_reg; // Edges since the last cause of a mode change
   // Restart the count on any pin change or write beat
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed(term_in) || $changed(motor_running_in) || $changed(start_cmd_in) || s_axi_wvalid)
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
         quiet_reg <= quiet_reg + 4'h1;
   end
   property p_reset;
      disable iff (1'b0) !aresetn |=> mode_out == 2'h0 && !output_stop_out;
   endproperty
   a_reset: assert property (p_reset) else $error("mode not cleared by reset");
   property p_quiet;
      quiet_reg > 4'h8 |-> $stable(mode_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("mode moved with no cause");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_rderr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rderr: assert property (p_rderr) else $error("unmapped read not refused");
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_wlat;
      s_wr_take |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_wrerr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h1c
         |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2;
   endproperty
   a_wrerr: assert property (p_wrerr) else $error("status write not refused");
   c_panel: cover property (mode_out == 2'h1);
   c_net: cover property (mode_out == 2'h2);
   c_comb: cover property (mode_out == 2'h3);
endmodule
bind oms_top oms_chk #(.NUM_TERM(NUM_TERM)) u_oms_chk (.*);

// ==== bench/oms_panel_model.sv ====
// Model of the input terminals and the operation panel
module oms_panel_model (
   input wire logic net_pu,
   input wire logic net_ext,
   input wire logic pu_ext,
   input wire logic lock,
   input wire logic run,
   output logic [4:0] term_in,
   output logic motor_running_in,
   output logic start_cmd_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Terminal wiring: 0 net-panel, 1 net-external, 2 panel-external, 3 interlock, 4 unused
   assign term_in = {1'b0, lock, pu_ext, net_ext, net_pu};
   // Running means motor turning with start on
   assign motor_running_in = run;
   assign start_cmd_in = run;
endmodule

// ==== bench/operation_mode_selector_test.sv ====
// Self-checking bench for the operation mode selector
module operation_mode_selector_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0; // Clock and reset
   logic net_pu = 1'b0, net_ext = 1'b0, pu_ext = 1'b0, lock = 1'b0, run = 1'b0; // Panel levels
   logic [4:0] term_in;
   logic motor_running_in, start_cmd_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, mode_out, rsp;
   logic output_stop_out;
   int err_count = 0, num_checks = 0;
   always #4 aclk = ~aclk;
   oms_top u_oms_top (.*);
   oms_panel_model u_oms_panel_model (.*);
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus write, address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Bus read
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Settings, then panel levels {net_pu,net_ext,pu_ext,lock,run}, then the mode after the pin latency
   task automatic step(input logic [3:0] op, input logic [3:0] cm, input logic [4:0] v, input logic [1:0] e);
      axi_wr(oms_pkg::OMS_OFS_OP_MODE, {28'h0, op}, rsp);
      axi_wr(oms_pkg::OMS_OFS_COMM, {28'h0, cm}, rsp);
      @(posedge aclk);
      {net_pu, net_ext, pu_ext, lock, run} <= v;
      repeat (4) @(posedge aclk);
      check({30'h0, mode_out}, {30'h0, e});
   endtask
   // Closing verdict
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      logic [6:0] fn [4];
      logic [3:0] ops [4];
      logic [1:0] fx [4];
      fn = '{7'h41, 7'h42, 7'h10, 7'h0c};
      ops = '{4'h1, 4'h2, 4'h3, 4'h4};
      fx = '{2'h1, 2'h2, 2'h3, 2'h3};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(oms_pkg::OMS_OFS_OP_MODE, rd, rsp);
      check(rd, 32'h0);
      axi_rd(oms_pkg::OMS_OFS_COMM, rd, rsp);
      check(rd, 32'h0);
      check({30'h0, mode_out}, 32'h0);
      axi_rd(8'h20, rd, rsp);
      check({rd[29:0], rsp}, {30'h0, 2'h2});
      axi_wr(oms_pkg::OMS_OFS_STATUS, 32'h3, rsp);
      check({30'h0, rsp}, 32'h2);
      $display("test reset and refusals done");
      for (int i = 0; i < 4; i++) begin
         axi_wr(oms_pkg::OMS_OFS_TERM0 + 8'(4 * i), {25'h0, fn[i]}, rsp);
         axi_rd(oms_pkg::OMS_OFS_TERM0 + 8'(4 * i), rd, rsp);
         check(rd, {25'h0, fn[i]});
      end
      for (int i = 0; i < 4; i++)
         step(ops[i], 4'ha, 5'b11100, fx[i]);
      $display("test fixed modes done");
      step(4'h0, 4'ha, 5'b10000, 2'h1);
      step(4'h0, 4'ha, 5'b00000, 2'h2);
      step(4'h0, 4'ha, 5'b11000, 2'h2);
      $display("test network-panel done");
      step(4'h2, 4'h0, 5'b01000, 2'h2);
      step(4'h2, 4'h0, 5'b00001, 2'h2);
      step(4'h2, 4'h0, 5'b10000, 2'h0);
      step(4'h6, 4'ha, 5'b10001, 2'h1);
      step(4'h6, 4'ha, 5'b11001, 2'h2);
      $display("test network-external and running done");
      step(4'h7, 4'h0, 5'b01000, 2'h0);
      check({31'h0, output_stop_out}, 32'h0);
      step(4'h7, 4'h0, 5'b01010, 2'h2);
      step(4'h7, 4'ha, 5'b00110, 2'h0);
      axi_rd(oms_pkg::OMS_OFS_STATUS, rd, rsp);
      check(rd, 32'hc);
      check({31'h0, output_stop_out}, 32'h1);
      $display("test interlock done");
      complete_run();
   end
endmodule
